// ===== core/parity_report.sv
// Purpose: Data parity error reporting of a two-bus bridge, with an APB
//          register file, parity error and system error pin drivers.
// Assumes: All inputs are synchronous to pclk; one data phase is
//          reported per cycle by the transaction queues.
// Notes:   Pin outputs come from flip-flops; wire resolution is external.
`include "parity_report_map.svh"

module parity_report (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Current transaction from the queues.
   input wire parity_report_pkg::xact_t xact_type,
   input wire logic xact_up,
   input wire logic completion,
   input wire logic init_err,
   // Parity detected by the bridge on each bus this data phase.
   input wire logic pri_dpe,
   input wire logic sec_dpe,
   // Parity error pins.
   input wire logic pri_parity_err_in_n,
   output logic pri_parity_err_n,
   output logic pri_parity_err_oe,
   input wire logic sec_parity_err_in_n,
   output logic sec_parity_err_n,
   output logic sec_parity_err_oe,
   // System error pin, open drain.
   output logic pri_system_err_n,
   output logic pri_system_err_oe,
   // Interrupt.
   output logic irq
);
   parity_report_pkg::report_state_t s;
   parity_report_pkg::report_state_t next_s;
   logic set_pri_dpd;
   logic set_sec_dpd;
   logic pri_perr_req;
   logic sec_perr_req;
   logic serr_req;
   logic access;
   logic wr_done;
   logic [`ST_W-1:0] set_vec;
   logic [`ST_W-1:0] clr_vec;

   // Tells whether an offset selects a register.
   function automatic logic is_mapped(input logic [11:0] a);
      return (a == `CTRL_OFS) || (a == `STATUS_OFS) ||
             (a == `CLEAR_OFS) || (a == `ENABLE_OFS);
   endfunction

   // Read view of the registers; the clear register reads as zero.
   function automatic logic [31:0] read_mux(
      input logic [11:0] a,
      input parity_report_pkg::report_state_t r);
      logic [31:0] d;
      d = '0;
      case (a)
         `CTRL_OFS: d[`CTRL_W-1:0] = r.ctrl;
         `STATUS_OFS: d[`ST_W-1:0] = r.status;
         `ENABLE_OFS: d[`ST_W-1:0] = r.irq_en;
         default: d = '0;
      endcase
      return d;
   endfunction

   // Event decode of the current data phase.
   parity_event_decode u_decode (
      .xact_type(xact_type),
      .xact_up(xact_up),
      .completion(completion),
      .init_err(init_err),
      .pri_dpe(pri_dpe),
      .sec_dpe(sec_dpe),
      .pri_perr_seen(~pri_parity_err_in_n),
      .sec_perr_seen(~sec_parity_err_in_n),
      .pri_resp(s.ctrl[`CTRL_PRI_RESP]),
      .sec_resp(s.ctrl[`CTRL_SEC_RESP]),
      .serr_en(s.ctrl[`CTRL_SERR_EN]),
      .pw_serr_dis(s.ctrl[`CTRL_PW_SERR_DIS]),
      .set_pri_dpd(set_pri_dpd),
      .set_sec_dpd(set_sec_dpd),
      .pri_perr_req(pri_perr_req),
      .sec_perr_req(sec_perr_req),
      .serr_req(serr_req)
   );

   // APB phases: the answer comes one cycle into the access phase.
   assign access = psel & penable & ~s.pready;
   assign wr_done = psel & penable & s.pready & pwrite;

   // Status events and software clears of the sticky bits.
   always_comb begin
      set_vec = '0;
      set_vec[`ST_PRI_DPD] = set_pri_dpd;
      set_vec[`ST_SEC_DPD] = set_sec_dpd;
      set_vec[`ST_SIG_SERR] = serr_req;
      clr_vec = '0;
      if (wr_done && (paddr == `STATUS_OFS || paddr == `CLEAR_OFS)) begin
         clr_vec = pwdata[`ST_W-1:0];
      end
   end

   // Next state of the whole block.
   always_comb begin
      next_s = s;
      // Bus answer.
      next_s.pready = access;
      next_s.pslverr = access & ~is_mapped(paddr);
      next_s.prdata = '0;
      if (access && !pwrite) begin
         next_s.prdata = read_mux(paddr, s);
      end
      // Register writes take effect at the completing edge.
      if (wr_done && paddr == `CTRL_OFS) begin
         next_s.ctrl = pwdata[`CTRL_W-1:0];
      end
      if (wr_done && paddr == `ENABLE_OFS) begin
         next_s.irq_en = pwdata[`ST_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      next_s.status = set_vec | (s.status & ~clr_vec);
      next_s.irq = |(next_s.status & next_s.irq_en);
      // Primary parity error: two-cycle delay, then one cycle driven
      // high again before the pin is released.
      next_s.pri_stage = pri_perr_req;
      next_s.pri_perr_n = ~(s.pri_stage & s.ctrl[`CTRL_PRI_RESP]);
      next_s.pri_oe = ~next_s.pri_perr_n | ~s.pri_perr_n;
      // Secondary parity error uses the same timing.
      next_s.sec_stage = sec_perr_req;
      next_s.sec_perr_n = ~(s.sec_stage & s.ctrl[`CTRL_SEC_RESP]);
      next_s.sec_oe = ~next_s.sec_perr_n | ~s.sec_perr_n;
      // System error is a one-cycle open-drain pulse.
      next_s.serr_n = ~serr_req;
      next_s.serr_oe = serr_req;
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.ctrl <= `CTRL_RST;
         s.status <= `ST_RST;
         s.irq_en <= `ENABLE_RST;
         s.pri_perr_n <= 1'h1;
         s.sec_perr_n <= 1'h1;
         s.serr_n <= 1'h1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register.
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign pri_parity_err_n = s.pri_perr_n;
   assign pri_parity_err_oe = s.pri_oe;
   assign sec_parity_err_n = s.sec_perr_n;
   assign sec_parity_err_oe = s.sec_oe;
   assign pri_system_err_n = s.serr_n;
   assign pri_system_err_oe = s.serr_oe;
   assign irq = s.irq;

   // Checks on the reporting behaviour.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Upstream primary error with response on sets the detected bit.
   a_pri_dpd_set:
      assert property (xact_up && !pri_parity_err_in_n &&
                       s.ctrl[`CTRL_PRI_RESP] |=> s.status[`ST_PRI_DPD])
      else $error("primary detected bit not set");

   // Secondary detected bit rises only when mastering downstream.
   a_sec_dpd_cause:
      assert property ($rose(s.status[`ST_SEC_DPD]) |->
                       $past(!xact_up && s.ctrl[`CTRL_SEC_RESP]))
      else $error("secondary detected bit set without cause");

   // Downstream secondary error with response on sets the bit.
   a_sec_dpd_set:
      assert property (!xact_up && sec_dpe && s.ctrl[`CTRL_SEC_RESP]
                       |=> s.status[`ST_SEC_DPD])
      else $error("secondary detected bit not set");

   // Primary parity error appears exactly two cycles after request.
   a_pri_perr_delay:
      assert property (pri_perr_req && s.ctrl[`CTRL_PRI_RESP] ##1
                       s.ctrl[`CTRL_PRI_RESP] |=> !pri_parity_err_n &&
                       pri_parity_err_oe)
      else $error("primary parity error late or missing");

   // Primary parity error never shows without its request.
   a_pri_perr_cause:
      assert property (!pri_parity_err_n |-> $past(pri_perr_req, 2) &&
                       pri_parity_err_oe)
      else $error("primary parity error without cause");

   // Downstream delayed completion error is forwarded to the primary.
   a_pri_perr_fwd:
      assert property (!xact_up &&
                       xact_type == parity_report_pkg::XT_DELAYED &&
                       completion && !sec_parity_err_in_n && !init_err &&
                       s.ctrl[`CTRL_PRI_RESP] && s.ctrl[`CTRL_SEC_RESP]
                       |-> pri_perr_req)
      else $error("completion error not forwarded to primary");

   // Secondary parity error follows its request by two cycles.
   a_sec_perr_delay:
      assert property (!sec_parity_err_n |->
                       $past(sec_perr_req, 2) && sec_parity_err_oe)
      else $error("secondary parity error without cause");

   // Upstream delayed completion error is forwarded to the secondary.
   a_sec_perr_fwd:
      assert property (xact_up &&
                       xact_type == parity_report_pkg::XT_DELAYED &&
                       completion && !pri_parity_err_in_n && !init_err &&
                       s.ctrl[`CTRL_PRI_RESP] && s.ctrl[`CTRL_SEC_RESP]
                       ##1 s.ctrl[`CTRL_SEC_RESP] ##1 1'b1
                       |-> !sec_parity_err_n)
      else $error("completion error not forwarded to secondary");

   // Posted write target error raises the system error pin.
   a_serr_posted:
      assert property (serr_req |=> !pri_system_err_n &&
                       pri_system_err_oe ##1
                       pri_system_err_n == !$past(serr_req))
      else $error("system error pulse wrong");

   // Forwarded errors never raise the system error pin.
   a_serr_fwd:
      assert property (!pri_system_err_n |-> !$past(init_err))
      else $error("system error for forwarded parity");

   // System error needs its enables and the disable bit clear.
   a_serr_enables:
      assert property (!pri_system_err_n |->
                       $past(s.ctrl) == 4'h7)
      else $error("system error with enables off");

   // Reads and delayed writes never raise the system error pin.
   a_serr_kind:
      assert property (!pri_system_err_n |->
                       $past(xact_type) == parity_report_pkg::XT_POSTED)
      else $error("system error for read or delayed write");

   // The disable bit blocks the system error pin.
   a_serr_disable:
      assert property (s.ctrl[`CTRL_PW_SERR_DIS] |=> pri_system_err_n)
      else $error("system error while disabled");

   // Every system error pulse sets the signaled bit.
   a_serr_signaled:
      assert property (!pri_system_err_n |-> s.status[`ST_SIG_SERR])
      else $error("signaled system error bit missing");

   // A written one clears a detected bit when no event sets it.
   a_status_clear:
      assert property (wr_done && paddr == `STATUS_OFS &&
                       pwdata[`ST_PRI_DPD] && !set_pri_dpd
                       |=> !s.status[`ST_PRI_DPD])
      else $error("detected bit not cleared");

   // Primary detected bit rises only on an upstream phase with response.
   a_pri_dpd_cause:
      assert property ($rose(s.status[`ST_PRI_DPD]) |->
                       $past(xact_up && s.ctrl[`CTRL_PRI_RESP]))
      else $error("primary detected bit set without cause");

   // Primary parity error pin is pulled only with its response bit.
   a_pri_perr_gate:
      assert property (!pri_parity_err_n |->
                       $past(s.ctrl[`CTRL_PRI_RESP]))
      else $error("primary parity error without response bit");

   // After its pulse the primary pin is driven high once, then released.
   a_pri_oe_tail:
      assert property ($rose(pri_parity_err_n) |-> pri_parity_err_oe ##1
                       pri_parity_err_oe == !pri_parity_err_n)
      else $error("primary parity error release wrong");

   // Secondary parity error pin is pulled only with its response bit.
   a_sec_perr_gate:
      assert property (!sec_parity_err_n |->
                       $past(s.ctrl[`CTRL_SEC_RESP]))
      else $error("secondary parity error without response bit");

   // After its pulse the secondary pin is driven high once, then released.
   a_sec_oe_tail:
      assert property ($rose(sec_parity_err_n) |-> sec_parity_err_oe ##1
                       sec_parity_err_oe == !sec_parity_err_n)
      else $error("secondary parity error release wrong");

   // The signaled bit rises only together with a system error pulse.
   a_sig_serr_cause:
      assert property ($rose(s.status[`ST_SIG_SERR]) |->
                       !pri_system_err_n)
      else $error("signaled bit set without system error");
endmodule

// ===== core/parity_report_map.svh
// Purpose: Register map, field positions and reset values for the
//          bridge data parity reporting block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
`ifndef PARITY_REPORT_MAP_SVH
`define PARITY_REPORT_MAP_SVH

// Register byte offsets.
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define CLEAR_OFS 12'h008
`define ENABLE_OFS 12'h00c

// Control register fields.
`define CTRL_W 4
`define CTRL_PRI_RESP 0
`define CTRL_SEC_RESP 1
`define CTRL_SERR_EN 2
`define CTRL_PW_SERR_DIS 3
`define CTRL_RST 4'h0

// Status, clear and enable register fields.
`define ST_W 3
`define ST_PRI_DPD 0
`define ST_SEC_DPD 1
`define ST_SIG_SERR 2
`define ST_RST 3'h0
`define ENABLE_RST 3'h0

`endif

// ===== core/parity_report_pkg.sv
// Purpose: Types shared by the parity reporting block.
// Assumes: The map header supplies field widths.
// Notes:   State is one packed struct registered as a whole.
`include "parity_report_map.svh"

package parity_report_pkg;

   // Kind of transaction that the queues report as current.
   typedef enum logic [1:0] {XT_READ, XT_POSTED, XT_DELAYED} xact_t;

   // Complete register state of the reporting block.
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [`CTRL_W-1:0] ctrl;
      logic [`ST_W-1:0] status;
      logic [`ST_W-1:0] irq_en;
      logic irq;
      logic pri_stage;
      logic pri_perr_n;
      logic pri_oe;
      logic sec_stage;
      logic sec_perr_n;
      logic sec_oe;
      logic serr_n;
      logic serr_oe;
   } report_state_t;

endpackage

// ===== core/parity_event_decode.sv
// Purpose: Decodes one data phase into parity reporting events.
// Assumes: Transaction kind and direction are valid with the error flags.
// Notes:   Purely combinational; the caller registers every result.
module parity_event_decode (
   // Current transaction.
   input wire parity_report_pkg::xact_t xact_type,
   input wire logic xact_up,
   input wire logic completion,
   input wire logic init_err,
   // Errors seen on each bus.
   input wire logic pri_dpe,
   input wire logic sec_dpe,
   input wire logic pri_perr_seen,
   input wire logic sec_perr_seen,
   // Control bits.
   input wire logic pri_resp,
   input wire logic sec_resp,
   input wire logic serr_en,
   input wire logic pw_serr_dis,
   // Decoded events.
   output logic set_pri_dpd,
   output logic set_sec_dpd,
   output logic pri_perr_req,
   output logic sec_perr_req,
   output logic serr_req
);
   logic is_read;
   logic is_posted;
   logic is_delayed;
   logic pri_err;
   logic sec_err;

   // Transaction kind and per-bus error summary.
   assign is_read = (xact_type == parity_report_pkg::XT_READ);
   assign is_posted = (xact_type == parity_report_pkg::XT_POSTED);
   assign is_delayed = (xact_type == parity_report_pkg::XT_DELAYED);
   assign pri_err = pri_dpe | pri_perr_seen;
   assign sec_err = sec_dpe | sec_perr_seen;

   // Detected bits follow the bus on which the bridge is master.
   assign set_pri_dpd = xact_up & pri_err & pri_resp;
   assign set_sec_dpd = ~xact_up & sec_err & sec_resp;

   // Primary parity error: own detection, or forwarded completion error.
   assign pri_perr_req = pri_resp &
      ((pri_dpe & (xact_up ? is_read : ~is_read)) |
       (~xact_up & is_delayed & completion & sec_perr_seen &
        ~init_err & sec_resp));

   // Secondary parity error mirrors the primary one.
   assign sec_perr_req = sec_resp &
      ((sec_dpe & (xact_up ? ~is_read : is_read)) |
       (xact_up & is_delayed & completion & pri_perr_seen &
        ~init_err & pri_resp));

   // System error only for posted writes with a target-reported error.
   assign serr_req = is_posted & ~init_err &
      (xact_up ? pri_perr_seen : sec_perr_seen) &
      serr_en & pri_resp & sec_resp & ~pw_serr_dis;
endmodule

// ===== tb/perr_wire_model.sv
// Purpose: Far-side agent that resolves one parity error wire.
// Assumes: The wire has a pull-up and a far target may pull it low.
// Notes:   A released wire reads high through the pull-up.
module perr_wire_model (
   // Bridge driver of the wire.
   input wire logic dev_n,
   input wire logic dev_oe,
   // Far target reports a data parity error this cycle.
   input wire logic tgt_err,
   // Resolved wire level.
   output logic wire_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Any driver low wins, otherwise the pull-up holds the wire high.
   assign wire_n = ~((dev_oe & ~dev_n) | tgt_err);
endmodule

// ===== tb/bridge_data_parity_reporting_tb.sv
// Purpose: Self-checking bench for the parity reporting block.
// Assumes: Far targets are modelled by the wire agents.
// Notes:   Each event phase clears the status first, then checks it.
`include "parity_report_map.svh"

module bridge_data_parity_reporting_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam parity_report_pkg::xact_t RD = parity_report_pkg::XT_READ;
   localparam parity_report_pkg::xact_t PW = parity_report_pkg::XT_POSTED;
   localparam parity_report_pkg::xact_t DW = parity_report_pkg::XT_DELAYED;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, er;
   parity_report_pkg::xact_t xact_type = RD;
   logic xact_up = 1'h0, completion = 1'h0, init_err = 1'h0;
   logic pri_dpe = 1'h0, sec_dpe = 1'h0, pri_tgt = 1'h0, sec_tgt = 1'h0;
   logic pri_wire_n, sec_wire_n, pp_n, pp_oe, sp_n, sp_oe, se_n, se_oe;
   int failures = 0, n_compared = 0, cycles = 0;

   // Clock of 40 ns period.
   initial forever #20 pclk = ~pclk;

   parity_report dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .xact_type, .xact_up,
      .completion, .init_err, .pri_dpe, .sec_dpe,
      .pri_parity_err_in_n(pri_wire_n), .pri_parity_err_n(pp_n),
      .pri_parity_err_oe(pp_oe), .sec_parity_err_in_n(sec_wire_n),
      .sec_parity_err_n(sp_n), .sec_parity_err_oe(sp_oe),
      .pri_system_err_n(se_n), .pri_system_err_oe(se_oe), .irq);
   perr_wire_model pri_u (.dev_n(pp_n), .dev_oe(pp_oe),
      .tgt_err(pri_tgt), .wire_n(pri_wire_n));
   perr_wire_model sec_u (.dev_n(sp_n), .dev_oe(sp_oe),
      .tgt_err(sec_tgt), .wire_n(sec_wire_n));

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Compares one value seen with the value expected.
   task automatic chk(input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits for pready, bounded so a hang is counted.
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n == 20)
         failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   // Reads a mapped register and compares it.
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
      chk(er, 1'h0);
   endtask

   // One data phase: kind, up, completion, forwarded, own errors, far
   // target errors, then expected status, primary and secondary pins.
   task automatic ph(input parity_report_pkg::xact_t t,
         input logic u, c, i, pd, sd, pw, sw,
         input logic [2:0] est, input logic epp, esp);
      wr(`CLEAR_OFS, 32'h7);
      @(posedge pclk);
      xact_type <= t;
      xact_up <= u;
      completion <= c;
      init_err <= i;
      pri_dpe <= pd;
      sec_dpe <= sd;
      pri_tgt <= pw;
      sec_tgt <= sw;
      @(posedge pclk);
      // Idle as a read, in the direction where our own pin echo sets no status.
      xact_type <= RD;
      xact_up <= esp;
      {completion, init_err, pri_dpe, sec_dpe} <= 4'h0;
      {pri_tgt, sec_tgt} <= 2'h0;
      #1;
      chk(se_n, !est[2]);
      chk(se_oe, est[2]);
      @(posedge pclk);
      #1;
      chk(pp_n, !epp);
      chk(pp_oe, epp);
      chk(sp_n, !esp);
      chk(sp_oe, esp);
      rdc(`STATUS_OFS, est);
   endtask

   // Reset values, access kinds, unmapped address and interrupt.
   task automatic t_regs();
      rdc(`CTRL_OFS, 32'h0);
      rdc(`STATUS_OFS, 32'h0);
      rdc(`ENABLE_OFS, 32'h0);
      wr(`CTRL_OFS, 32'hffff_ffff);
      rdc(`CTRL_OFS, 32'hf);
      rdc(`CLEAR_OFS, 32'h0);
      apb(1'h0, 12'h010, 32'h0);
      chk(er, 1'h1);
      chk(rd, 32'h0);
      wr(`CTRL_OFS, 32'h3);
      wr(`ENABLE_OFS, 32'h1);
      rdc(`ENABLE_OFS, 32'h1);
      ph(RD, 1, 0, 0, 1, 0, 0, 0, 3'h1, 1, 0);
      chk(irq, 1'h1);
      wr(`ENABLE_OFS, 32'h0);
      @(posedge pclk);
      #1;
      chk(irq, 1'h0);
      wr(`ENABLE_OFS, 32'h1);
      wr(`STATUS_OFS, 32'h0);
      rdc(`STATUS_OFS, 32'h1);
      chk(irq, 1'h1);
      wr(`STATUS_OFS, 32'h1);
      rdc(`STATUS_OFS, 32'h0);
      chk(irq, 1'h0);
      wr(`ENABLE_OFS, 32'h0);
   endtask

   // Detected bits and pins for each kind, direction and bus.
   task automatic t_detect();
      ph(PW, 1, 0, 0, 0, 0, 1, 0, 3'h1, 0, 0);
      ph(DW, 1, 0, 0, 1, 0, 0, 0, 3'h1, 0, 0);
      ph(PW, 0, 0, 0, 1, 0, 0, 0, 3'h0, 1, 0);
      ph(DW, 0, 0, 0, 1, 0, 0, 0, 3'h0, 1, 0);
      ph(RD, 0, 0, 0, 1, 0, 0, 0, 3'h0, 0, 0);
      ph(RD, 0, 0, 0, 0, 1, 0, 0, 3'h2, 0, 1);
      ph(PW, 0, 0, 0, 0, 0, 0, 1, 3'h2, 0, 0);
      ph(DW, 0, 0, 0, 0, 1, 0, 0, 3'h2, 0, 0);
      ph(PW, 1, 0, 0, 0, 1, 0, 0, 3'h0, 0, 1);
      ph(DW, 1, 0, 0, 0, 1, 0, 0, 3'h0, 0, 1);
      ph(RD, 1, 0, 0, 0, 1, 0, 0, 3'h0, 0, 0);
      wr(`CTRL_OFS, 32'h2);
      ph(RD, 1, 0, 0, 1, 0, 0, 0, 3'h0, 0, 0);
      wr(`CTRL_OFS, 32'h1);
      ph(RD, 0, 0, 0, 0, 1, 0, 0, 3'h0, 0, 0);
   endtask

   // Errors reported by the target during delayed write completion.
   task automatic t_fwd();
      wr(`CTRL_OFS, 32'h3);
      ph(DW, 0, 1, 0, 0, 0, 0, 1, 3'h2, 1, 0);
      ph(DW, 0, 1, 1, 0, 0, 0, 1, 3'h2, 0, 0);
      ph(DW, 1, 1, 0, 0, 0, 1, 0, 3'h1, 0, 1);
      wr(`CTRL_OFS, 32'h1);
      ph(DW, 0, 1, 0, 0, 0, 0, 1, 3'h0, 0, 0);
      wr(`CTRL_OFS, 32'h2);
      ph(DW, 1, 1, 0, 0, 0, 1, 0, 3'h0, 0, 0);
   endtask

   // System error for posted writes, and its gating conditions.
   task automatic t_serr();
      wr(`CTRL_OFS, 32'h7);
      ph(PW, 0, 0, 0, 0, 0, 0, 1, 3'h6, 0, 0);
      ph(PW, 1, 0, 0, 0, 0, 1, 0, 3'h5, 0, 0);
      ph(PW, 0, 0, 1, 0, 0, 0, 1, 3'h2, 0, 0);
      ph(DW, 0, 0, 0, 0, 0, 0, 1, 3'h2, 0, 0);
      ph(RD, 0, 0, 0, 0, 0, 0, 1, 3'h2, 0, 0);
      ph(DW, 0, 1, 0, 0, 0, 0, 1, 3'h2, 1, 0);
      wr(`CTRL_OFS, 32'hf);
      ph(PW, 0, 0, 0, 0, 0, 0, 1, 3'h2, 0, 0);
      wr(`CTRL_OFS, 32'h5);
      ph(PW, 0, 0, 0, 0, 0, 0, 1, 3'h0, 0, 0);
      wr(`CTRL_OFS, 32'h3);
      ph(PW, 1, 0, 0, 0, 0, 1, 0, 3'h1, 0, 0);
   endtask

   // Cuts a hang short after a generous cycle ceiling.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end

   // Main sequence: reset for six cycles, then every scenario.
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_detect();
      t_fwd();
      t_serr();
      wrap_up();
   end
endmodule
